// ---- pkg/pcrcap_defs.svh ----
`ifndef PCRCAP_DEFS_SVH
`define PCRCAP_DEFS_SVH
// configuration byte offsets
`define PCRCAP_OFS_INT_PIN 8'h3D
`define PCRCAP_OFS_PM_HDR 8'h50
`define PCRCAP_OFS_PM_CAPS 8'h52
`define PCRCAP_OFS_PM_CSR 8'h54
`define PCRCAP_OFS_EXP_HDR 8'h58
`define PCRCAP_OFS_EXP_CAPS 8'h5A
`define PCRCAP_OFS_DEV_CAPS 8'h5C
`define PCRCAP_OFS_DEV_CTL 8'h60
`define PCRCAP_OFS_DEV_STS 8'h62
`define PCRCAP_OFS_LINK_CAPS 8'h64
// capability list constants
`define PCRCAP_PM_CAPABILITY_IDENTIFIER 8'h01
`define PCRCAP_PM_NEXT 8'h58
`define PCRCAP_EXP_CAPABILITY_IDENTIFIER 8'h10
`define PCRCAP_EXP_NEXT 8'h80
`define PCRCAP_LIST_END 8'h00
// hardwired field values
`define PCRCAP_PM_VERSION 3'h3
`define PCRCAP_PME_STATE_MASK 5'h19
`define PCRCAP_EXP_VERSION 4'h1
`define PCRCAP_PORT_TYPE_ROOT 4'h4
`define PCRCAP_MAX_PAYLOAD_SUP 3'h0
`define PCRCAP_EXT_TAG_SUP 1'h1
`define PCRCAP_LINK_SPEED 4'h1
`define PCRCAP_ASPM_SUPPORT 2'h3
`define PCRCAP_L0S_EXIT 3'h1
`define PCRCAP_L1_EXIT 3'h2
`define PCRCAP_LINK_UP_CAP 1'h1
// writable field reset values and device control write mask
`define PCRCAP_RST_INT_PIN 3'h0
`define PCRCAP_RST_DEV_CTL 16'h0810
`define PCRCAP_DEV_CTL_WMASK 16'h09FF
// tag widths
`define PCRCAP_TAG_MASK_SHORT 8'h1F
`define PCRCAP_TAG_MASK_LONG 8'hFF
`endif

// ---- pkg/pcrcap_pkg.sv ----
package pcrcap_pkg;
   // register selected by a configuration access
   typedef enum logic [10:0] {
      PCRCAP_SEL_NONE = 11'h000,
      PCRCAP_SEL_INT_PIN = 11'h001,
      PCRCAP_SEL_PM_HDR = 11'h002,
      PCRCAP_SEL_PM_CAPS = 11'h004,
      PCRCAP_SEL_PM_CSR = 11'h008,
      PCRCAP_SEL_EXP_HDR = 11'h010,
      PCRCAP_SEL_EXP_CAPS = 11'h020,
      PCRCAP_SEL_DEV_CAPS = 11'h040,
      PCRCAP_SEL_DEV_CTL = 11'h080,
      PCRCAP_SEL_DEV_STS = 11'h100,
      PCRCAP_SEL_LINK_CAPS = 11'h200,
      PCRCAP_SEL_UNUSED = 11'h400
   } pcrcap_sel_type;
endpackage

// ---- core/pcrcap_regs.sv ----
`timescale 1ns/10ps
`include "pcrcap_defs.svh"
module pcrcap_regs #(
   parameter logic [5:0] LINK_WIDTH = 6'h01, // maximum lane count encoding
   parameter logic [7:0] PORT_NUMBER = 8'h00 // port number of this link
) (
   input wire logic CLOCK_I, // 50 MHz clock
   input wire logic SRST_I, // synchronous reset, high
   input wire logic CFG_WR_I, // configuration write strobe
   input wire logic CFG_RD_I, // configuration read strobe
   input wire logic [7:0] CFG_ADDR_I, // byte address, register aligned
   input wire logic [3:0] CFG_BE_I, // byte enables of the access
   input wire logic [31:0] CFG_WDATA_I, // write data, low aligned
   output logic [31:0] CFG_RDATA_O, // read data, low aligned
   output logic CFG_ACK_O, // access done pulse
   input wire logic CORRECTABLE_SEEN_I, // correctable error pulse
   input wire logic NONFATAL_ERR_I, // non-fatal error pulse
   input wire logic FATAL_ERR_I, // fatal error pulse
   input wire logic UNSUP_REQ_I, // unsupported request pulse
   input wire logic AUX_NEEDED_I, // port requires aux power
   input wire logic AUX_PRESENT_I, // aux power pin, async
   input wire logic NP_PENDING_I, // own non-posted requests open
   input wire logic PM_EVENT_I, // power event pulse
   output logic [1:0] POWER_STATE_O, // selected power state
   output logic PM_EVENT_ENABLE_O, // power event enable
   output logic [3:0] ERR_REPORT_EN_O, // cor, nonfatal, fatal, ur enables
   output logic LOOSE_ORDERING_EN_O, // relaxed ordering permitted
   output logic NO_SNOOP_EN_O, // no-snoop permitted
   output logic [2:0] MAX_PAYLOAD_O, // payload size code
   output logic [7:0] TAG_MASK_O, // usable requester tag bits
   output logic SLOT_IMPL_O, // link wired to a slot
   output logic [2:0] INT_PIN_O // legacy interrupt pin code
);

   logic [2:0] int_pin_ff;
   logic [1:0] power_state_ff;
   logic pm_event_enable_ff;
   logic [3:0] data_select_ff;
   logic pm_event_flag_ff;
   logic slot_impl_ff;
   logic [15:0] dev_ctl_ff;
   logic [3:0] err_seen_ff;
   logic aux_meta_ff;
   logic aux_sync_ff;
   logic [31:0] rdata_ff;
   logic ack_ff;
   logic [31:0] nxt_rdata;
   pcrcap_pkg::pcrcap_sel_type sel;
   logic wr;
   logic [31:0] wmask;
   logic [3:0] err_pulse;
   logic [15:0] nxt_dev_ctl;
   logic [7:0] tag_mask_ff;
   logic wr_pin;
   logic wr_pm_csr;
   logic wr_exp_caps;
   logic wr_dev_ctl;
   logic wr_dev_sts;
   logic [31:0] pin_word;
   logic [31:0] pm_hdr_word;
   logic [31:0] pm_caps_word;
   logic [31:0] pm_csr_word;
   logic [31:0] exp_hdr_word;
   logic [31:0] exp_caps_word;
   logic [31:0] dev_caps_word;
   logic [31:0] dev_ctl_word;
   logic [31:0] dev_sts_word;
   logic [31:0] link_caps_word;

   // byte-enable expansion, used for write masking and read data masking
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction

   // address decode into a one-hot select
   always_comb begin
      case (CFG_ADDR_I)
         `PCRCAP_OFS_INT_PIN: sel = pcrcap_pkg::PCRCAP_SEL_INT_PIN;
         `PCRCAP_OFS_PM_HDR: sel = pcrcap_pkg::PCRCAP_SEL_PM_HDR;
         `PCRCAP_OFS_PM_CAPS: sel = pcrcap_pkg::PCRCAP_SEL_PM_CAPS;
         `PCRCAP_OFS_PM_CSR: sel = pcrcap_pkg::PCRCAP_SEL_PM_CSR;
         `PCRCAP_OFS_EXP_HDR: sel = pcrcap_pkg::PCRCAP_SEL_EXP_HDR;
         `PCRCAP_OFS_EXP_CAPS: sel = pcrcap_pkg::PCRCAP_SEL_EXP_CAPS;
         `PCRCAP_OFS_DEV_CAPS: sel = pcrcap_pkg::PCRCAP_SEL_DEV_CAPS;
         `PCRCAP_OFS_DEV_CTL: sel = pcrcap_pkg::PCRCAP_SEL_DEV_CTL;
         `PCRCAP_OFS_DEV_STS: sel = pcrcap_pkg::PCRCAP_SEL_DEV_STS;
         `PCRCAP_OFS_LINK_CAPS: sel = pcrcap_pkg::PCRCAP_SEL_LINK_CAPS;
         default: sel = pcrcap_pkg::PCRCAP_SEL_NONE;
      endcase
   end

   assign wr = CFG_WR_I;
   assign wmask = be_mask(CFG_BE_I);

   // per-register write hits; a write to any other offset changes nothing
   // but is still acknowledged, so software never stalls on it
   assign wr_pin = wr && (sel == pcrcap_pkg::PCRCAP_SEL_INT_PIN);
   assign wr_pm_csr = wr && (sel == pcrcap_pkg::PCRCAP_SEL_PM_CSR);
   assign wr_exp_caps = wr && (sel == pcrcap_pkg::PCRCAP_SEL_EXP_CAPS);
   assign wr_dev_ctl = wr && (sel == pcrcap_pkg::PCRCAP_SEL_DEV_CTL);
   assign wr_dev_sts = wr && (sel == pcrcap_pkg::PCRCAP_SEL_DEV_STS);

   // error inputs gathered in status bit order, so one index walks
   // both the event and the matching write-one-to-clear bit
   assign err_pulse = {UNSUP_REQ_I, FATAL_ERR_I, NONFATAL_ERR_I, CORRECTABLE_SEEN_I};

   // aux power pin is asynchronous: two stages before use
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         aux_meta_ff <= 1'h0;
         aux_sync_ff <= 1'h0;
      end else begin
         aux_meta_ff <= AUX_PRESENT_I;
         aux_sync_ff <= aux_meta_ff;
      end
   end

   // interrupt pin: only three low bits are storage
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         int_pin_ff <= `PCRCAP_RST_INT_PIN;
      end else if (wr_pin && CFG_BE_I[0]) begin
         int_pin_ff <= CFG_WDATA_I[2:0];
      end
   end

   // power management control fields
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         power_state_ff <= 2'h0;
         pm_event_enable_ff <= 1'h0;
         data_select_ff <= 4'h0;
      end else if (wr_pm_csr) begin
         if (CFG_BE_I[0]) begin
            power_state_ff <= CFG_WDATA_I[1:0];
         end
         if (CFG_BE_I[1]) begin
            pm_event_enable_ff <= CFG_WDATA_I[8];
            data_select_ff <= CFG_WDATA_I[12:9];
         end
      end
   end

   // power event flag: write one clears, a new event wins
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         pm_event_flag_ff <= 1'h0;
      end else if (PM_EVENT_I) begin
         pm_event_flag_ff <= 1'h1;
      end else if (wr_pm_csr && CFG_BE_I[1] && CFG_WDATA_I[15]) begin
         pm_event_flag_ff <= 1'h0;
      end
   end

   // slot implemented sits in the upper byte of the capabilities half
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         slot_impl_ff <= 1'h0;
      end else if (wr_exp_caps && CFG_BE_I[1]) begin
         slot_impl_ff <= CFG_WDATA_I[8];
      end
   end

   // next device control value: only listed fields take writes,
   // so read-only and reserved bits keep their reset value
   always_comb begin
      nxt_dev_ctl = dev_ctl_ff;
      if (wr_dev_ctl) begin
         nxt_dev_ctl = (dev_ctl_ff & ~(`PCRCAP_DEV_CTL_WMASK & wmask[15:0])) |
                       (CFG_WDATA_I[15:0] & `PCRCAP_DEV_CTL_WMASK & wmask[15:0]);
      end
   end

   // device control register; its enable bits leave as plain levels
   // so the requester logic sees a change on the edge after the write
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         dev_ctl_ff <= `PCRCAP_RST_DEV_CTL;
      end else begin
         dev_ctl_ff <= nxt_dev_ctl;
      end
   end

   // tag mask kept in its own register so the port comes from a flip-flop;
   // loaded from the next control value, so it never lags the enable bit
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         tag_mask_ff <= `PCRCAP_TAG_MASK_SHORT;
      end else if (nxt_dev_ctl[8]) begin
         tag_mask_ff <= `PCRCAP_TAG_MASK_LONG;
      end else begin
         tag_mask_ff <= `PCRCAP_TAG_MASK_SHORT;
      end
   end

   // error seen bits: detection beats a same-cycle write-one clear,
   // so an error that lands on the clearing write is never lost
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         err_seen_ff <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (err_pulse[i]) begin
               err_seen_ff[i] <= 1'h1;
            end else if (wr_dev_sts && CFG_BE_I[0] && CFG_WDATA_I[i]) begin
               err_seen_ff[i] <= 1'h0;
            end
         end
      end
   end

   // interrupt pin image: only the three stored bits can be non-zero,
   // the five upper bits are hardwired low
   always_comb begin
      pin_word = 32'h0000_0000;
      pin_word[2:0] = int_pin_ff;
   end

   // power management capability header, first entry of the list;
   // it points on to the express capability
   always_comb begin
      pm_hdr_word = 32'h0000_0000;
      pm_hdr_word[7:0] = `PCRCAP_PM_CAPABILITY_IDENTIFIER;
      pm_hdr_word[15:8] = `PCRCAP_PM_NEXT;
   end

   // power management capabilities; event clock bit 3 and the
   // unsupported sleep-state bits all stay low
   always_comb begin
      pm_caps_word = 32'h0000_0000;
      pm_caps_word[2:0] = `PCRCAP_PM_VERSION;
      pm_caps_word[15:11] = `PCRCAP_PME_STATE_MASK;
   end

   // power management status and control; bus state and bus power
   // bits 22 and 23 stay low since they mean nothing on this link
   always_comb begin
      pm_csr_word = 32'h0000_0000;
      pm_csr_word[1:0] = power_state_ff;
      pm_csr_word[8] = pm_event_enable_ff;
      pm_csr_word[12:9] = data_select_ff;
      pm_csr_word[15] = pm_event_flag_ff;
   end

   // express capability header; the next offset leads past this bank,
   // so the list continues in logic outside this block
   always_comb begin
      exp_hdr_word = 32'h0000_0000;
      exp_hdr_word[7:0] = `PCRCAP_EXP_CAPABILITY_IDENTIFIER;
      exp_hdr_word[15:8] = `PCRCAP_EXP_NEXT;
   end

   // express capabilities: version, root port type, slot bit;
   // the interrupt message number is not used and reads zero
   always_comb begin
      exp_caps_word = 32'h0000_0000;
      exp_caps_word[3:0] = `PCRCAP_EXP_VERSION;
      exp_caps_word[7:4] = `PCRCAP_PORT_TYPE_ROOT;
      exp_caps_word[8] = slot_impl_ff;
   end

   // device capabilities: 128-byte payload, extended tags offered;
   // every other field is hardwired low
   always_comb begin
      dev_caps_word = 32'h0000_0000;
      dev_caps_word[2:0] = `PCRCAP_MAX_PAYLOAD_SUP;
      dev_caps_word[5] = `PCRCAP_EXT_TAG_SUP;
   end

   // device control image; read-only bits come back as stored,
   // which is their reset value since writes never reach them
   always_comb begin
      dev_ctl_word = 32'h0000_0000;
      dev_ctl_word[15:0] = dev_ctl_ff;
   end

   // device status; the pending bit and the aux needed input are live levels, but the aux pin comes through the two-stage sync,
   // so a read shows the pending state of the cycle the strobe was taken in
   always_comb begin
      dev_sts_word = 32'h0000_0000;
      dev_sts_word[3:0] = err_seen_ff;
      dev_sts_word[4] = AUX_NEEDED_I & aux_sync_ff;
      dev_sts_word[5] = NP_PENDING_I;
   end

   // link capabilities; width and port number are per-instance
   // parameters because each port of the device differs there
   always_comb begin
      link_caps_word = 32'h0000_0000;
      link_caps_word[3:0] = `PCRCAP_LINK_SPEED;
      link_caps_word[9:4] = LINK_WIDTH;
      link_caps_word[11:10] = `PCRCAP_ASPM_SUPPORT;
      link_caps_word[14:12] = `PCRCAP_L0S_EXIT;
      link_caps_word[17:15] = `PCRCAP_L1_EXIT;
      link_caps_word[20] = `PCRCAP_LINK_UP_CAP;
      link_caps_word[31:24] = PORT_NUMBER;
   end

   // read mux; unmapped offsets fall out as zero, as do reserved bits
   // of every word above
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      case (sel)
         pcrcap_pkg::PCRCAP_SEL_INT_PIN: nxt_rdata = pin_word;
         pcrcap_pkg::PCRCAP_SEL_PM_HDR: nxt_rdata = pm_hdr_word;
         pcrcap_pkg::PCRCAP_SEL_PM_CAPS: nxt_rdata = pm_caps_word;
         pcrcap_pkg::PCRCAP_SEL_PM_CSR: nxt_rdata = pm_csr_word;
         pcrcap_pkg::PCRCAP_SEL_EXP_HDR: nxt_rdata = exp_hdr_word;
         pcrcap_pkg::PCRCAP_SEL_EXP_CAPS: nxt_rdata = exp_caps_word;
         pcrcap_pkg::PCRCAP_SEL_DEV_CAPS: nxt_rdata = dev_caps_word;
         pcrcap_pkg::PCRCAP_SEL_DEV_CTL: nxt_rdata = dev_ctl_word;
         pcrcap_pkg::PCRCAP_SEL_DEV_STS: nxt_rdata = dev_sts_word;
         pcrcap_pkg::PCRCAP_SEL_LINK_CAPS: nxt_rdata = link_caps_word;
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   // read data and acknowledge, one cycle after the strobe; read data
   // is cut by the byte enables, so a narrow read of a wide register
   // shows zero in the lanes it did not ask for
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         rdata_ff <= 32'h0000_0000;
         ack_ff <= 1'h0;
      end else begin
         ack_ff <= CFG_RD_I | CFG_WR_I;
         if (CFG_RD_I) begin
            rdata_ff <= nxt_rdata & wmask;
         end
      end
   end

   assign CFG_RDATA_O = rdata_ff;
   assign CFG_ACK_O = ack_ff;
   assign POWER_STATE_O = power_state_ff;
   assign PM_EVENT_ENABLE_O = pm_event_enable_ff;
   assign ERR_REPORT_EN_O = dev_ctl_ff[3:0];
   assign LOOSE_ORDERING_EN_O = dev_ctl_ff[4];
   assign NO_SNOOP_EN_O = dev_ctl_ff[11];
   assign MAX_PAYLOAD_O = dev_ctl_ff[7:5];
   assign TAG_MASK_O = tag_mask_ff;
   assign SLOT_IMPL_O = slot_impl_ff;
   assign INT_PIN_O = int_pin_ff;

endmodule // pcrcap_regs

// ---- testbench/pcrcap_regs_monitor.sv ----
`timescale 1ns/10ps
// watches access timing and the fixed fields of the register bank
module pcrcap_regs_monitor #(
   parameter logic [5:0] LINK_WIDTH = 6'h01, // lane count code
   parameter logic [7:0] PORT_NUMBER = 8'h00 // port number
) (
   input wire logic CLOCK_I, // clock
   input wire logic SRST_I, // reset
   input wire logic CFG_WR_I, // write strobe
   input wire logic CFG_RD_I, // read strobe
   input wire logic [7:0] CFG_ADDR_I, // offset
   input wire logic [3:0] CFG_BE_I, // byte enables
   input wire logic [31:0] CFG_WDATA_I, // write data
   input wire logic [31:0] CFG_RDATA_O, // read data
   input wire logic CFG_ACK_O, // ack
   input wire logic [7:0] TAG_MASK_O, // tag mask
   input wire logic [2:0] INT_PIN_O, // pin code
   input wire logic LOOSE_ORDERING_EN_O, // ordering enable
   input wire logic NO_SNOOP_EN_O, // no-snoop enable
   input wire logic [2:0] MAX_PAYLOAD_O // payload code
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SRST_I);
   // 16-bit reads and control writes; upper bytes must come back zero
   wire logic rd16 = CFG_RD_I && CFG_BE_I == 4'h3;
   wire logic wr60 = CFG_WR_I && CFG_ADDR_I == 8'h60 && CFG_BE_I[1];
   ack_follows_strobe_a: assert property ((CFG_RD_I || CFG_WR_I) |=> CFG_ACK_O)
      else $error("no ack one cycle after a strobe");
   pin_upper_zero_a: assert property (CFG_RD_I && CFG_ADDR_I == 8'h3D && CFG_BE_I[0]
      |=> CFG_RDATA_O[7:0] == {5'h00, INT_PIN_O}) else $error("interrupt pin read wrong");
   pm_header_a: assert property (rd16 && CFG_ADDR_I == 8'h50
      |=> CFG_RDATA_O == 32'h00005801) else $error("power header read wrong");
   pm_caps_a: assert property (rd16 && CFG_ADDR_I == 8'h52
      |=> CFG_RDATA_O == 32'h0000C803) else $error("power capabilities read wrong");
   exp_header_a: assert property (rd16 && CFG_ADDR_I == 8'h58
      |=> CFG_RDATA_O == 32'h00008010) else $error("express header read wrong");
   port_type_a: assert property (rd16 && CFG_ADDR_I == 8'h5A
      |=> CFG_RDATA_O[7:0] == 8'h41) else $error("port type read wrong");
   link_caps_a: assert property (CFG_RD_I && CFG_ADDR_I == 8'h64 && CFG_BE_I == 4'hF
      |=> CFG_RDATA_O == {PORT_NUMBER, 3'h0, 1'h1, 2'h0, 3'h2, 3'h1, 2'h3, LINK_WIDTH, 4'h1})
      else $error("link capabilities read wrong");
   tag_long_a: assert property (wr60 && CFG_WDATA_I[8] |=> TAG_MASK_O == 8'hFF)
      else $error("long tags not enabled");
   tag_short_a: assert property (wr60 && !CFG_WDATA_I[8] |=> TAG_MASK_O == 8'h1F)
      else $error("short tags not enforced");
   reset_ctl_a: assert property ($fell(SRST_I) |-> LOOSE_ORDERING_EN_O && NO_SNOOP_EN_O
      && MAX_PAYLOAD_O == 3'h0) else $error("control reset value wrong");
   cover property (wr60 && CFG_WDATA_I[8]);
   cover property (rd16 && CFG_ADDR_I == 8'h62);
   cover property (CFG_RD_I && CFG_ADDR_I == 8'h64);
endmodule // pcrcap_regs_monitor
bind pcrcap_regs pcrcap_regs_monitor #(.LINK_WIDTH(LINK_WIDTH), .PORT_NUMBER(PORT_NUMBER))
   u_pcrcap_regs_monitor (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .CFG_WR_I(CFG_WR_I),
   .CFG_RD_I(CFG_RD_I), .CFG_ADDR_I(CFG_ADDR_I), .CFG_BE_I(CFG_BE_I),
   .CFG_WDATA_I(CFG_WDATA_I), .CFG_RDATA_O(CFG_RDATA_O), .CFG_ACK_O(CFG_ACK_O),
   .TAG_MASK_O(TAG_MASK_O), .INT_PIN_O(INT_PIN_O), .LOOSE_ORDERING_EN_O(LOOSE_ORDERING_EN_O),
   .NO_SNOOP_EN_O(NO_SNOOP_EN_O), .MAX_PAYLOAD_O(MAX_PAYLOAD_O));

// ---- testbench/test_pcrcap_regs.sv ----
`timescale 1ns/10ps
module test_pcrcap_regs;
   // register table: offsets, reset values, plain writable bits (flags clear by ones)
   localparam logic [7:0] OFS [11] = '{8'h3D, 8'h50, 8'h52, 8'h54, 8'h58, 8'h5A, 8'h5C,
      8'h60, 8'h62, 8'h64, 8'h44};
   localparam logic [31:0] RST [11] = '{32'h0, 32'h5801, 32'hC803, 32'h0, 32'h8010, 32'h41,
      32'h20, 32'h810, 32'h0, 32'h07111C41, 32'h0};
   localparam logic [31:0] WM [11] = '{32'h7, 32'h0, 32'h0, 32'h1F03, 32'h0, 32'h100, 32'h0,
      32'h9FF, 32'h0, 32'h0, 32'h0};
   logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, aux_n = 1'b0, aux_p = 1'b0;
   logic np = 1'b0, pme = 1'b0, ack, pm_event_enable, lo, ns, slot;
   logic [3:0] be = 4'h0, err = 4'h0, err_en;
   logic [7:0] addr = 8'h00, tag;
   logic [31:0] wdata = 32'h0, rdata, r, mdl [11];
   logic [2:0] mps, pin;
   logic [1:0] pst;
   int num_errors = 0, compares = 0, k;
   pcrcap_regs #(.LINK_WIDTH(6'h04), .PORT_NUMBER(8'h07)) u_pcrcap_regs (.CLOCK_I(clk),
      .SRST_I(srst), .CFG_WR_I(wr), .CFG_RD_I(rd), .CFG_ADDR_I(addr), .CFG_BE_I(be),
      .CFG_WDATA_I(wdata), .CFG_RDATA_O(rdata), .CFG_ACK_O(ack), .CORRECTABLE_SEEN_I(err[0]),
      .NONFATAL_ERR_I(err[1]), .FATAL_ERR_I(err[2]), .UNSUP_REQ_I(err[3]),
      .AUX_NEEDED_I(aux_n), .AUX_PRESENT_I(aux_p), .NP_PENDING_I(np), .PM_EVENT_I(pme),
      .POWER_STATE_O(pst), .PM_EVENT_ENABLE_O(pm_event_enable), .ERR_REPORT_EN_O(err_en),
      .LOOSE_ORDERING_EN_O(lo), .NO_SNOOP_EN_O(ns), .MAX_PAYLOAD_O(mps), .TAG_MASK_O(tag),
      .SLOT_IMPL_O(slot), .INT_PIN_O(pin));
   initial begin
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // control outputs follow the modelled registers
   function automatic logic [31:0] outs_exp();
      return {8'h0, mdl[3][1:0], mdl[3][8], mdl[7][3:0], mdl[7][4], mdl[7][11], mdl[7][7:5],
         mdl[7][8] ? 8'hFF : 8'h1F, mdl[5][8], mdl[0][2:0]};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one access; ack stands for the single cycle after the taking edge
   task automatic acc(input logic w, input int i, input logic [31:0] d);
      @(negedge clk);
      wr = w;
      rd = ~w;
      addr = OFS[i];
      wdata = d;
      be = (i == 0) ? 4'h1 : (i inside {3, 6, 9, 10}) ? 4'hF : 4'h3;
      @(posedge clk);
      #1;
      check({31'h0, ack}, 32'h1); // refused writes still answer
      if (w) mdl[i] = (mdl[i] & ~WM[i]) | (d & WM[i]);
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
   endtask
   task automatic rchk(input int i, input logic [31:0] e);
      acc(1'b0, i, 32'h0);
      check(rdata, e); // read value
   endtask
   task automatic do_reset();
      @(negedge clk);
      srst = 1'b1;
      repeat (20) @(negedge clk);
      srst = 1'b0;
      mdl = RST;
   endtask
   task automatic read_all(input string s);
      for (int i = 0; i < 11; i++) rchk(i, mdl[i]);
      check({8'h0, pst, pm_event_enable, err_en, lo, ns, mps, tag, slot, pin}, outs_exp());
      $display("test %0s done", s);
   endtask
   task automatic pulse(input logic [4:0] v);
      @(negedge clk);
      {pme, err} = v;
      @(negedge clk);
      {pme, err} = 5'h00;
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      give_verdict();
   end
   initial begin
      do_reset();
      read_all("reset");
      r = 32'h6;
      // random writes everywhere, including fixed fields and an unmapped offset
      repeat (80) begin
         r = lfsr(r);
         k = int'(r[7:0]) % 11;
         acc(1'b1, k, r);
         rchk(k, mdl[k]);
         check({8'h0, pst, pm_event_enable, err_en, lo, ns, mps, tag, slot, pin}, outs_exp());
      end
      $display("test random done");
      for (int i = 0; i < 4; i++) begin
         pulse(5'h01 << i);
         rchk(8, 32'h1 << i); // error flags
         acc(1'b1, 8, 32'h1 << i);
         rchk(8, 32'h0);
      end
      @(negedge clk);
      {aux_n, aux_p, np} = 3'h7;
      repeat (4) @(negedge clk);
      rchk(8, 32'h30);
      {aux_p, np} = 2'h0;
      repeat (4) @(negedge clk);
      rchk(8, 32'h0);
      pulse(5'h10);
      rchk(3, mdl[3] | 32'h8000);
      acc(1'b1, 3, mdl[3] | 32'h8000);
      rchk(3, mdl[3]);
      // event and write-one clear in one cycle: the event must win
      pulse(5'h10);
      fork
         pulse(5'h10);
         acc(1'b1, 3, mdl[3] | 32'h8000);
      join
      rchk(3, mdl[3] | 32'h8000);
      acc(1'b1, 3, mdl[3] | 32'h8000);
      rchk(3, mdl[3]);
      $display("test status done");
      do_reset();
      read_all("second reset");
      give_verdict();
   end
endmodule // test_pcrcap_regs
